// >>> verilog/ffh_pkg.sv
// Shared constants, register map and status carriers for the flagged buffer
package ffh_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FFH_OFF_CTRL = 8'h00;
    localparam logic [7:0] FFH_OFF_FULL_THR = 8'h04;
    localparam logic [7:0] FFH_OFF_EMPTY_THR = 8'h08;
    localparam logic [7:0] FFH_OFF_STATUS = 8'h0C;
    localparam logic [7:0] FFH_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] FFH_OFF_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------
    // Control, threshold and status field positions
    // ------------------------------------------------------------
    localparam int FFH_CTRL_ACK_LOW = 0;
    localparam int FFH_CTRL_OVF_LOW = 1;
    localparam int FFH_CTRL_VAL_LOW = 2;
    localparam int FFH_CTRL_UNF_LOW = 3;
    localparam int FFH_CTRL_ACK_EN = 4;
    localparam int FFH_CTRL_OVF_EN = 5;
    localparam int FFH_CTRL_VAL_EN = 6;
    localparam int FFH_CTRL_UNF_EN = 7;
    localparam int FFH_CTRL_FULL_MODE = 8;
    localparam int FFH_CTRL_EMPTY_MODE = 10;
    localparam int FFH_CTRL_INJ1_EN = 12;
    localparam int FFH_CTRL_INJ2_EN = 13;
    localparam int FFH_THR_NEG = 16;
    localparam int FFH_STAT_FLAGS = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [13:0] FFH_CTRL_RST = 14'h00F0;
    localparam logic [15:0] FFH_FULL_ASSERT_RST = 16'h03FE;
    localparam logic [15:0] FFH_FULL_NEGATE_RST = 16'h03FD;
    localparam logic [15:0] FFH_EMPTY_ASSERT_RST = 16'h0002;
    localparam logic [15:0] FFH_EMPTY_NEGATE_RST = 16'h0003;
    localparam logic [4:0] FFH_IRQ_RST = 5'h00;

    // Interrupt bit positions
    localparam int FFH_IRQ_OVF = 0;
    localparam int FFH_IRQ_UNF = 1;
    localparam int FFH_IRQ_SBE = 2;
    localparam int FFH_IRQ_DBE = 3;
    localparam int FFH_IRQ_THR = 4;

    // AXI responses
    localparam logic [1:0] FFH_RESP_OKAY = 2'h0;
    localparam logic [1:0] FFH_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FFH_THR_NONE = 2'b00,
        FFH_THR_SINGLE = 2'b01,
        FFH_THR_MULTI = 2'b10
    } ffh_thr_mode_t;

    typedef enum logic [1:0] {
        FFH_RST_SYNC = 2'b00,
        FFH_RST_ASYNC = 2'b01,
        FFH_RST_NONE = 2'b10,
        FFH_RST_SPLIT = 2'b11
    } ffh_rst_kind_t;

    // ------------------------------------------------------------
    // Status carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic full;
        logic almost_full;
        logic threshold_high_flag;
        logic wr_ack;
        logic overflow;
    } ffh_wr_stat_t;

    typedef struct packed {
        logic empty;
        logic almost_empty;
        logic threshold_low_flag;
        logic valid;
        logic underflow;
        logic single_bit_error_flag;
        logic double_bit_error_flag;
    } ffh_rd_stat_t;
endpackage

// >>> verilog/ffh_fifo_flags.sv
// Flagged buffer with handshake outputs, fault injection, reset options and register slave
//
// Overview of operation
// - almost full when one word of room remains
// - almost empty when one word remains stored
// - acknowledge pulse marks accepted write
// - overflow pulse marks rejected write, contents kept
// - valid marks read data output valid
// - underflow pulse marks rejected read
// - handshake outputs polarity selectable, default high
// - one-bit fault injection, flagged on readback
// - two-bit fault injection, flagged on readback
// - full-type flags held constant during reset
// - optional read data reset constant
// - otherwise read data keeps value through reset
// - separate write and read resets selectable
// - sync, async or no reset selectable
// - single full threshold uses assert only
// - single empty threshold uses assert only
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module ffh_fifo_flags
    import ffh_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int DEPTH = 1024,
    parameter ffh_rst_kind_t RST_KIND = FFH_RST_SYNC,
    parameter bit FULL_RST_VAL = 1'b1,
    parameter bit DOUT_RST_EN = 1'b1,
    parameter logic [DATA_W-1:0] DOUT_RST_VAL = '0,
    parameter bit ECC_EN = 1'b1
)
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic fifo_srst, // buffer reset, synchronous
    input wire logic fifo_arst, // buffer reset, asynchronous
    input wire logic wr_rst, // write side reset
    input wire logic rd_rst, // read side reset
    input wire logic wr_en, // write request
    input wire logic [DATA_W-1:0] din, // write data
    input wire logic inject_one_bit_fault, // corrupt one bit of this write
    input wire logic inject_two_bit_fault, // corrupt two bits of this write
    input wire logic rd_en, // read request
    output logic [DATA_W-1:0] dout, // read data
    output ffh_wr_stat_t wr_status, // write side flags
    output ffh_rd_stat_t rd_status, // read side flags
    output logic irq, // interrupt level
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_C = (AW+1)'(1);

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic one_fault;
        logic two_fault;
    } ffh_entry_t;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [13:0] ctrl;
    logic [15:0] full_assert;
    logic [15:0] full_negate;
    logic [15:0] empty_assert;
    logic [15:0] empty_negate;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;

    // ------------------------------------------------------------
    // Reset selection
    // ------------------------------------------------------------
    logic [1:0] arst_sync;
    logic wr_rst_act;
    logic rd_rst_act;

    // Async assert, release aligned to the clock
    always_ff @(posedge aclk or posedge fifo_arst)
    begin
        if (fifo_arst)
            arst_sync <= 2'b00;
        else
            arst_sync <= {arst_sync[0], 1'b1};
    end

    always_comb
    begin
        case (RST_KIND)
            FFH_RST_SYNC:
            begin
                wr_rst_act = !aresetn || fifo_srst;
                rd_rst_act = !aresetn || fifo_srst;
            end
            FFH_RST_ASYNC:
            begin
                wr_rst_act = !aresetn || !arst_sync[1];
                rd_rst_act = !aresetn || !arst_sync[1];
            end
            FFH_RST_SPLIT:
            begin
                wr_rst_act = !aresetn || wr_rst;
                rd_rst_act = !aresetn || rd_rst;
            end
            default:
            begin
                wr_rst_act = !aresetn;
                rd_rst_act = !aresetn;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    ffh_entry_t mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] count;
    logic full_raw;
    logic empty_raw;
    logic wr_ok;
    logic rd_ok;
    logic inj1;
    logic inj2;
    ffh_entry_t next_entry;

    assign count = wptr - rptr;
    assign full_raw = (count == DEPTH_C);
    assign empty_raw = (count == '0);
    assign wr_ok = wr_en && !full_raw && !wr_rst_act;
    assign rd_ok = rd_en && !empty_raw && !rd_rst_act;
    assign inj1 = ECC_EN && ctrl[FFH_CTRL_INJ1_EN] && inject_one_bit_fault;
    assign inj2 = ECC_EN && ctrl[FFH_CTRL_INJ2_EN] && inject_two_bit_fault;

    always_comb
    begin
        next_entry.data = din;
        next_entry.one_fault = 1'b0;
        next_entry.two_fault = 1'b0;
        if (inj2)
        begin
            next_entry.data[1:0] = ~din[1:0];
            next_entry.two_fault = 1'b1;
        end
        else if (inj1)
        begin
            next_entry.data[0] = ~din[0];
            next_entry.one_fault = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (wr_ok)
            mem[wptr[AW-1:0]] <= next_entry;
    end

    always_ff @(posedge aclk)
    begin
        if (wr_rst_act)
            wptr <= '0;
        else if (wr_ok)
            wptr <= wptr + ONE_C;
    end

    always_ff @(posedge aclk)
    begin
        if (rd_rst_act)
            rptr <= '0;
        else if (rd_ok)
            rptr <= rptr + ONE_C;
    end

    // ------------------------------------------------------------
    // Write side handshake and flags
    // ------------------------------------------------------------
    logic ack_q;
    logic ovf_q;
    logic thr_high;

    always_ff @(posedge aclk)
    begin
        if (wr_rst_act)
        begin
            ack_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            ack_q <= wr_ok;
            ovf_q <= wr_en && !wr_ok;
        end
    end

    // Hysteresis only in multi mode; single mode ignores negate
    always_ff @(posedge aclk)
    begin
        if (wr_rst_act)
            thr_high <= 1'b0;
        else
        begin
            case (ffh_thr_mode_t'(ctrl[FFH_CTRL_FULL_MODE +: 2]))
                FFH_THR_SINGLE:
                    thr_high <= (16'(count) >= full_assert);
                FFH_THR_MULTI:
                    if (16'(count) >= full_assert)
                        thr_high <= 1'b1;
                    else if (16'(count) < full_negate)
                        thr_high <= 1'b0;
                default:
                    thr_high <= 1'b0;
            endcase
        end
    end

    always_comb
    begin
        if (wr_rst_act)
        begin
            wr_status.full = FULL_RST_VAL;
            wr_status.almost_full = FULL_RST_VAL;
            wr_status.threshold_high_flag = FULL_RST_VAL;
        end
        else
        begin
            wr_status.full = full_raw;
            wr_status.almost_full = (count == DEPTH_C - ONE_C);
            wr_status.threshold_high_flag = thr_high;
        end
        wr_status.wr_ack = (ack_q && ctrl[FFH_CTRL_ACK_EN]) ^ ctrl[FFH_CTRL_ACK_LOW];
        wr_status.overflow = (ovf_q && ctrl[FFH_CTRL_OVF_EN]) ^ ctrl[FFH_CTRL_OVF_LOW];
    end

    // ------------------------------------------------------------
    // Read side data, handshake and flags
    // ------------------------------------------------------------
    ffh_entry_t rd_entry;
    logic val_q;
    logic unf_q;
    logic sbe_q;
    logic dbe_q;
    logic thr_low;

    assign rd_entry = mem[rptr[AW-1:0]];

    always_ff @(posedge aclk)
    begin
        if (rd_rst_act)
        begin
            if (DOUT_RST_EN)
                dout <= DOUT_RST_VAL;
        end
        else if (rd_ok)
        begin
            dout <= rd_entry.data;
            if (rd_entry.one_fault)
                dout[0] <= ~rd_entry.data[0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rd_rst_act)
        begin
            val_q <= 1'b0;
            unf_q <= 1'b0;
            sbe_q <= 1'b0;
            dbe_q <= 1'b0;
        end
        else
        begin
            val_q <= rd_ok;
            unf_q <= rd_en && !rd_ok;
            sbe_q <= rd_ok && rd_entry.one_fault;
            dbe_q <= rd_ok && rd_entry.two_fault;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rd_rst_act)
            thr_low <= 1'b1;
        else
        begin
            case (ffh_thr_mode_t'(ctrl[FFH_CTRL_EMPTY_MODE +: 2]))
                FFH_THR_SINGLE:
                    thr_low <= (16'(count) <= empty_assert);
                FFH_THR_MULTI:
                    if (16'(count) <= empty_assert)
                        thr_low <= 1'b1;
                    else if (16'(count) >= empty_negate)
                        thr_low <= 1'b0;
                default:
                    thr_low <= 1'b0;
            endcase
        end
    end

    always_comb
    begin
        rd_status.empty = empty_raw || rd_rst_act;
        rd_status.almost_empty = (count == ONE_C) && !rd_rst_act;
        rd_status.threshold_low_flag = thr_low;
        rd_status.valid = (val_q && ctrl[FFH_CTRL_VAL_EN]) ^ ctrl[FFH_CTRL_VAL_LOW];
        rd_status.underflow = (unf_q && ctrl[FFH_CTRL_UNF_EN]) ^ ctrl[FFH_CTRL_UNF_LOW];
        rd_status.single_bit_error_flag = sbe_q;
        rd_status.double_bit_error_flag = dbe_q;
    end

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic addr_ok;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [4:0] irq_event;
    logic thr_high_d;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign addr_ok = (aw_addr[1:0] == 2'b00) && (aw_addr <= FFH_OFF_IRQ_MASK);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FFH_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok ? FFH_RESP_OKAY : FFH_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Strobes honoured on the lanes each field covers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= FFH_CTRL_RST;
            full_assert <= FFH_FULL_ASSERT_RST;
            full_negate <= FFH_FULL_NEGATE_RST;
            empty_assert <= FFH_EMPTY_ASSERT_RST;
            empty_negate <= FFH_EMPTY_NEGATE_RST;
            irq_mask <= FFH_IRQ_RST;
        end
        else if (do_write)
        begin
            case (aw_addr)
                FFH_OFF_CTRL:
                begin
                    if (w_strb[0])
                        ctrl[7:0] <= w_data[7:0];
                    if (w_strb[1])
                        ctrl[13:8] <= w_data[13:8];
                end
                FFH_OFF_FULL_THR:
                begin
                    if (&w_strb[1:0])
                        full_assert <= w_data[15:0];
                    if (&w_strb[3:2])
                        full_negate <= w_data[FFH_THR_NEG +: 16];
                end
                FFH_OFF_EMPTY_THR:
                begin
                    if (&w_strb[1:0])
                        empty_assert <= w_data[15:0];
                    if (&w_strb[3:2])
                        empty_negate <= w_data[FFH_THR_NEG +: 16];
                end
                FFH_OFF_IRQ_MASK:
                    if (w_strb[0])
                        irq_mask <= w_data[4:0];
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over write-one-clear
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            thr_high_d <= 1'b0;
        else
            thr_high_d <= thr_high;
    end

    always_comb
    begin
        irq_event = '0;
        irq_event[FFH_IRQ_OVF] = ovf_q;
        irq_event[FFH_IRQ_UNF] = unf_q;
        irq_event[FFH_IRQ_SBE] = sbe_q;
        irq_event[FFH_IRQ_DBE] = dbe_q;
        irq_event[FFH_IRQ_THR] = thr_high && !thr_high_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat <= FFH_IRQ_RST;
        else if (do_write && aw_addr == FFH_OFF_IRQ_STAT && w_strb[0])
            irq_stat <= (irq_stat & ~w_data[4:0]) | irq_event;
        else
            irq_stat <= irq_stat | irq_event;
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            FFH_OFF_CTRL: rd_word[13:0] = ctrl;
            FFH_OFF_FULL_THR: rd_word = {full_negate, full_assert};
            FFH_OFF_EMPTY_THR: rd_word = {empty_negate, empty_assert};
            FFH_OFF_STATUS:
            begin
                rd_word[AW:0] = count;
                rd_word[FFH_STAT_FLAGS +: 5] = wr_status;
                rd_word[FFH_STAT_FLAGS + 5 +: 7] = rd_status;
            end
            FFH_OFF_IRQ_STAT: rd_word[4:0] = irq_stat;
            FFH_OFF_IRQ_MASK: rd_word[4:0] = irq_mask;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= FFH_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? FFH_RESP_OKAY : FFH_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// >>> dv/ffh_fifo_flags_properties.sv
// Port checks for the flagged buffer
module ffh_fifo_flags_properties
    import ffh_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter bit FULL_RST_VAL = 1'b1,
    parameter logic [DATA_W-1:0] DOUT_RST_VAL = '0
)
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic fifo_srst, // buffer reset
    input wire logic wr_en, // write request
    input wire logic rd_en, // read request
    input wire logic [DATA_W-1:0] dout, // read data
    input wire ffh_wr_stat_t wr_status, // write flags
    input wire ffh_rd_stat_t rd_status, // read flags
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid // r valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || fifo_srst);

    property p_af_fill; wr_en && !rd_en && wr_status.almost_full |=> wr_status.full; endproperty
    a_af_fill: assert property (p_af_fill) else $error("last free word not filled");
    // Flags settle only two edges after release
    property p_af_excl; $past(aresetn, 2) && wr_status.full |-> !wr_status.almost_full; endproperty
    a_af_excl: assert property (p_af_excl) else $error("almost full while full");
    property p_ae_drain; rd_en && !wr_en && rd_status.almost_empty |=> rd_status.empty; endproperty
    a_ae_drain: assert property (p_ae_drain) else $error("last word not drained");
    property p_ae_excl; $past(aresetn, 2) && rd_status.empty |-> !rd_status.almost_empty; endproperty
    a_ae_excl: assert property (p_ae_excl) else $error("almost empty while empty");
    property p_ovf_keep; wr_en && !rd_en && wr_status.full |=> wr_status.full; endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("rejected write changed level");
    property p_rst_full; disable iff (1'b0) !aresetn ##1 !aresetn |-> wr_status.full == FULL_RST_VAL
        && wr_status.almost_full == FULL_RST_VAL && wr_status.threshold_high_flag == FULL_RST_VAL; endproperty
    a_rst_full: assert property (p_rst_full) else $error("full flags not held in reset");
    property p_rst_dout; disable iff (1'b0) !aresetn ##1 !aresetn |-> dout == DOUT_RST_VAL; endproperty
    a_rst_dout: assert property (p_rst_dout) else $error("read data not reset");
    property p_bresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rresp: assert property (p_rresp) else $error("read response late");

    c_ovf: cover property (wr_en && wr_status.full);
    c_unf: cover property (rd_en && rd_status.empty);
    c_wr: cover property (s_axi_bvalid);
endmodule

bind ffh_fifo_flags ffh_fifo_flags_properties #(.DATA_W(DATA_W), .FULL_RST_VAL(FULL_RST_VAL),
    .DOUT_RST_VAL(DOUT_RST_VAL)) ffh_fifo_flags_properties_i (.*);

// >>> dv/ffh_user_model.sv
// User logic that writes and reads the buffer
module ffh_user_model
(
    input wire logic aclk, // clock
    output logic wr_en, // write request
    output logic [17:0] din, // write data
    output logic f1, // one-bit fault
    output logic f2, // two-bit fault
    output logic rd_en // read request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en, din, f1, f2, rd_en} = '0;

    task automatic push(input logic [17:0] d, input logic a, input logic b);
        @(posedge aclk);
        {wr_en, din, f1, f2} <= {1'b1, d, a, b};
        @(posedge aclk);
        // Stale data inverted
        {wr_en, din, f1, f2} <= {1'b0, ~d, 2'b00};
        #1;
    endtask

    task automatic pop();
        @(posedge aclk);
        rd_en <= 1'b1;
        @(posedge aclk);
        rd_en <= 1'b0;
        #1;
    endtask
endmodule

// >>> dv/test_ffh_fifo_flags.sv
// Directed bench for the flagged buffer and its register slave
module test_ffh_fifo_flags
    import ffh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] DRST = 18'h2A5A5;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic zero = 1'b0;
    logic wr_en, rd_en, f1, f2, irq;
    logic [17:0] din, dout;
    ffh_wr_stat_t wst;
    ffh_rd_stat_t rds;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fails = 0, cmp_count = 0;

    always #10 aclk = ~aclk;

    ffh_fifo_flags #(.DEPTH(4), .DOUT_RST_VAL(DRST)) ffh_fifo_flags_i (.*, .fifo_srst(zero), .fifo_arst(zero),
        .wr_rst(zero), .rd_rst(zero), .inject_one_bit_fault(f1), .inject_two_bit_fault(f2), .wr_status(wst),
        .rd_status(rds));
    ffh_user_model ffh_user_model_i (.aclk, .wr_en, .din, .f1, .f2, .rd_en);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Each channel released at the edge that takes it; only the watchdog ends a wait
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        #1;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        #1;
    endtask

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge aclk);
        #1;
        chk(dout, DRST);
        chk(wst.full, 1'b1);
        chk(wst.almost_full, 1'b1);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(FFH_OFF_CTRL, d, r);
        chk(d, 32'h0000_00F0);
        axr(FFH_OFF_FULL_THR, d, r);
        chk(d, 32'h03FD_03FE);
        axr(8'h18, d, r);
        chk(r, FFH_RESP_SLVERR);
        chk(d, 32'h0);
        $display("test registers ended");
        for (int i = 0; i < 4; i++)
        begin
            ffh_user_model_i.push(18'h00100 + i, 1'b0, 1'b0);
            chk(wst.wr_ack, 1'b1);
            chk(wst.almost_full, i == 2);
            chk(wst.full, i == 3);
        end
        ffh_user_model_i.push(18'h3FFFF, 1'b0, 1'b0);
        chk(wst.overflow, 1'b1);
        chk(wst.wr_ack, 1'b0);
        @(posedge aclk);
        #1;
        chk(irq, 1'b0);
        axw(FFH_OFF_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        axw(FFH_OFF_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        $display("test fill ended");
        for (int i = 0; i < 4; i++)
        begin
            ffh_user_model_i.pop();
            chk(dout, 18'h00100 + i);
            chk(rds.valid, 1'b1);
            chk(rds.almost_empty, i == 2);
        end
        ffh_user_model_i.pop();
        chk(rds.underflow, 1'b1);
        chk(rds.valid, 1'b0);
        chk(dout, 18'h00103);
        $display("test drain ended");
        axw(FFH_OFF_CTRL, 32'h0000_00FF);
        ffh_user_model_i.push(18'h00055, 1'b0, 1'b0);
        chk(wst.wr_ack, 1'b0);
        chk(wst.overflow, 1'b1);
        ffh_user_model_i.pop();
        chk(rds.valid, 1'b0);
        chk(rds.underflow, 1'b1);
        $display("test polarity ended");
        axw(FFH_OFF_CTRL, 32'h0000_30F0);
        ffh_user_model_i.push(18'h12340, 1'b1, 1'b0);
        ffh_user_model_i.push(18'h12340, 1'b0, 1'b1);
        ffh_user_model_i.pop();
        chk(dout, 18'h12340);
        chk(rds.single_bit_error_flag, 1'b1);
        ffh_user_model_i.pop();
        chk(dout, 18'h12343);
        chk(rds.double_bit_error_flag, 1'b1);
        $display("test faults ended");
        axw(FFH_OFF_FULL_THR, 32'h0001_0002);
        axw(FFH_OFF_EMPTY_THR, 32'h0003_0001);
        axw(FFH_OFF_CTRL, 32'h0000_05F0);
        repeat (2) ffh_user_model_i.push(18'h00001, 1'b0, 1'b0);
        @(posedge aclk);
        #1;
        chk(wst.threshold_high_flag, 1'b1);
        chk(rds.threshold_low_flag, 1'b0);
        ffh_user_model_i.pop();
        @(posedge aclk);
        #1;
        chk(wst.threshold_high_flag, 1'b0);
        chk(rds.threshold_low_flag, 1'b1);
        $display("test thresholds ended");
        give_verdict();
    end

    initial
    begin
        #100us;
        fails++;
        give_verdict();
    end
endmodule
